// File: rtl/dbg_pkg.sv
// Shared constants and types for the debug comparator and trace capture block
package dbg_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_ADDR_W = 16;
  localparam int unsigned LINE_W = 64;
  localparam int unsigned ENTRY_W = 32;
  localparam int unsigned LINE_IDX_W = 6;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned TIMESTAMP_ENABLE_W = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] OFS_DEBUG_CONTROL = 16'h0100;
  localparam logic [15:0] OFS_DEBUG_STATUS = 16'h0102;
  localparam logic [15:0] OFS_TRACE_LINE_COUNTER = 16'h0106;
  localparam logic [15:0] OFS_TRACE_CONTROL_LOW = 16'h0107;
  localparam logic [15:0] OFS_TRACE_READ_LINE = 16'h010A;
  localparam logic [15:0] OFS_COMPARATOR_A_CONTROL = 16'h0110;
  localparam logic [15:0] OFS_CMP_ADDR_HIGH = 16'h0115;
  localparam logic [15:0] OFS_CMP_ADDR_MID = 16'h0116;
  localparam logic [15:0] OFS_CMP_ADDR_LOW = 16'h0117;
  localparam logic [15:0] OFS_CMP_DATA = 16'h0118;
  localparam logic [15:0] OFS_TRACE_DATA_BASE = 16'h0120;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_DATA_MISMATCH_SELECT = 6;
  localparam int unsigned BIT_PC_COMPARE_SELECT = 5;
  localparam int unsigned BIT_READ_WRITE_VALUE = 3;
  localparam int unsigned BIT_READ_WRITE_COMPARE_ENABLE = 2;
  localparam int unsigned BIT_COMPARATOR_ENABLE = 0;
  localparam int unsigned BIT_ARM = 7;
  localparam int unsigned BIT_STATUS_PROFILING = 7;
  localparam int unsigned BIT_TIMESTAMP_ENABLE = 0;
  localparam int unsigned BIT_SINGLE_SOURCE = 1;
  localparam int unsigned BIT_TRACE_MODE_LO = 2;
  localparam int unsigned BIT_TRACE_ENABLE = 4;
  localparam int unsigned BIT_INFO_SOURCE = 24;
  localparam int unsigned BIT_INFO_DEST = 25;
  localparam int unsigned BIT_INFO_VECTOR = 26;
  localparam int unsigned BIT_INFO_EXT_EVENT = 27;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] RST_COMPARATOR_A_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRACE_CONTROL_LOW = 8'h00;
  localparam logic [7:0] MASK_COMPARATOR_A_CONTROL = 8'h6D;
  localparam logic [7:0] MASK_TRACE_CONTROL_LOW = 8'h1F;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_LOOP1 = 2'h1;
  localparam logic [1:0] COF_SOURCE = 2'h0;
  localparam logic [1:0] COF_DEST = 2'h1;
  localparam logic [1:0] COF_VECTOR = 2'h2;
  localparam logic [2:0] SSF_IDLE = 3'h0;
  localparam logic [2:0] SSF_STATE1 = 3'h1;
  localparam logic [2:0] SSF_FINAL = 3'h4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STATE1,
    SEQ_FINAL
  } seq_state_t;

endpackage : dbg_pkg

// File: rtl/dbg_comparator.sv
// Address comparator A with data and access direction qualification
`timescale 1ns/1ps
module dbg_comparator (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration
  input wire logic [7:0] ctrl_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] cmp_addr_i,
  input wire logic [dbg_pkg::DATA_W-1:0] cmp_data_i,
  // Core bus and program flow
  input wire logic bus_valid_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic [dbg_pkg::DATA_W-1:0] bus_data_i,
  input wire logic bus_read_i,
  input wire logic pc_valid_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] pc_i,
  // Result
  output logic match_o
);

  typedef struct packed {
    logic match;
  } cmp_state_t;

  cmp_state_t s_q;
  cmp_state_t s_d;
  logic enable;
  logic pc_sel;
  logic data_mismatch_select;
  logic read_write_compare_enable;
  logic rw_val;
  logic data_ok;
  logic dir_ok;

  always_comb begin
    enable = ctrl_i[dbg_pkg::BIT_COMPARATOR_ENABLE];
    pc_sel = ctrl_i[dbg_pkg::BIT_PC_COMPARE_SELECT];
    data_mismatch_select = ctrl_i[dbg_pkg::BIT_DATA_MISMATCH_SELECT];
    read_write_compare_enable = ctrl_i[dbg_pkg::BIT_READ_WRITE_COMPARE_ENABLE];
    rw_val = ctrl_i[dbg_pkg::BIT_READ_WRITE_VALUE];
    data_ok = data_mismatch_select ? (bus_data_i != cmp_data_i) : (bus_data_i == cmp_data_i);
    dir_ok = !read_write_compare_enable || (rw_val == bus_read_i);
    s_d = s_q;
    if (!enable) begin
      s_d.match = 1'b0;
    end else if (pc_sel) begin
      // Data and direction are meaningless for executed opcodes
      s_d.match = pc_valid_i && (pc_i == cmp_addr_i);
    end else begin
      s_d.match = bus_valid_i && (bus_addr_i == cmp_addr_i) && data_ok && dir_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign match_o = s_q.match;

endmodule : dbg_comparator

// File: rtl/dbg_trace_ram.sv
// Trace buffer storage: eight byte lines with a write enable for each half
`timescale 1ns/1ps
module dbg_trace_ram (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic [1:0] we_i,
  input wire logic [dbg_pkg::LINE_IDX_W-1:0] waddr_i,
  input wire logic [dbg_pkg::LINE_W-1:0] wdata_i,
  // Read port
  input wire logic [dbg_pkg::LINE_IDX_W-1:0] raddr_i,
  output logic [dbg_pkg::LINE_W-1:0] rdata_o
);

  localparam int unsigned DEPTH = 1 << dbg_pkg::LINE_IDX_W;
  localparam int unsigned HALF_W = dbg_pkg::LINE_W / 2;

  logic [dbg_pkg::LINE_W-1:0] mem [DEPTH];

  // No reset: contents are undefined until written, as in the real buffer
  for (genvar h = 0; h < 2; h++) begin : g_half
    always_ff @(posedge clk_i) begin
      if (we_i[h]) begin
        mem[waddr_i][h*HALF_W +: HALF_W] <= wdata_i[h*HALF_W +: HALF_W];
      end
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule : dbg_trace_ram

// File: rtl/dbg_trace_capture.sv
// Debug comparator control, state sequencer and trace capture top level
//
// How it works
// - Data-mismatch select chooses equality or difference; ignored under PC compare.
// - PC-compare select picks program counter or data access address.
// - Read/write value bit picks write at 0, read at 1.
// - Read/write enable adds access direction to the compare; ignored under PC compare.
// - Comparator only matches while its enable bit is set.
// - Comparator control always readable, writable only when disarmed and not profiling.
// - State sequence flag never shows 101, 110 or 111.
// - Indexed jump stores its destination even if an interrupt coincides.
// - Untimestamped normal and loop1 pack two entries per line; counter low bit steps per entry.
// - Each entry carries source, destination and vector information bits.
// - External event forces an entry of last PC with event bit set.
// - Event coinciding with a flow change gives one entry with event bit set.
// - Timestamp enable with single source uses the timestamped normal format.
// - Each trace buffer line is eight bytes wide.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module dbg_trace_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [dbg_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Core data bus
  input wire logic bus_valid_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic [dbg_pkg::DATA_W-1:0] bus_data_i,
  input wire logic bus_read_i,
  // Core program flow
  input wire logic pc_valid_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] pc_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] last_pc_i,
  input wire logic cof_valid_i,
  input wire logic [1:0] cof_kind_i,
  input wire logic [dbg_pkg::ADDR_W-1:0] cof_addr_i,
  // Profiling status and external event pin
  input wire logic profiling_active_i,
  input wire logic ext_event_i,
  // Status
  output logic match_o,
  output logic armed_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] rdata;
    logic arm;
    dbg_pkg::seq_state_t seq;
    logic [7:0] actl;
    logic [dbg_pkg::ADDR_W-1:0] cmp_addr;
    logic [dbg_pkg::DATA_W-1:0] cmp_data;
    logic [7:0] tctl;
    logic [dbg_pkg::CNT_W-1:0] cnt;
    logic [dbg_pkg::LINE_IDX_W-1:0] rd_line;
    logic [dbg_pkg::TIMESTAMP_ENABLE_W-1:0] timestamp_enable;
    logic [dbg_pkg::ADDR_W-1:0] prev_addr;
    logic prev_valid;
    logic [2:0] eev_sync;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic cmp_match;
  logic [1:0] ram_we;
  logic [dbg_pkg::LINE_W-1:0] ram_wdata;
  logic [dbg_pkg::LINE_W-1:0] ram_rdata;
  logic ext_edge;
  logic entry_req;
  logic [dbg_pkg::ENTRY_W-1:0] entry;
  logic [dbg_pkg::ADDR_W-1:0] entry_addr;
  logic timestamp_enable_fmt;
  logic loop1_skip;
  logic ctl_wr_ok;
  logic tracing;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] ssf_code(input dbg_pkg::seq_state_t st);
    unique case (st)
      dbg_pkg::SEQ_IDLE: ssf_code = dbg_pkg::SSF_IDLE;
      dbg_pkg::SEQ_STATE1: ssf_code = dbg_pkg::SSF_STATE1;
      dbg_pkg::SEQ_FINAL: ssf_code = dbg_pkg::SSF_FINAL;
      default: ssf_code = dbg_pkg::SSF_IDLE;
    endcase
  endfunction : ssf_code

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================================
  // Comparator and buffer
  dbg_comparator u_cmp (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ctrl_i(s_q.actl),
    .cmp_addr_i(s_q.cmp_addr),
    .cmp_data_i(s_q.cmp_data),
    .bus_valid_i(bus_valid_i),
    .bus_addr_i(bus_addr_i),
    .bus_data_i(bus_data_i),
    .bus_read_i(bus_read_i),
    .pc_valid_i(pc_valid_i),
    .pc_i(pc_i),
    .match_o(cmp_match)
  );

  dbg_trace_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(s_q.cnt[dbg_pkg::CNT_W-1:1]),
    .wdata_i(ram_wdata),
    .raddr_i(s_q.rd_line),
    .rdata_o(ram_rdata)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    ram_we = 2'h0;
    ram_wdata = '0;

    // The second and third stages feed the edge detector
    s_d.eev_sync = {s_q.eev_sync[1:0], ext_event_i};
    ext_edge = s_q.eev_sync[1] && !s_q.eev_sync[2];
    s_d.timestamp_enable = s_q.timestamp_enable + 16'h0001;

    ctl_wr_ok = !s_q.arm && !profiling_active_i;

    // Trace entry build
    tracing = s_q.arm && s_q.tctl[dbg_pkg::BIT_TRACE_ENABLE];
    entry_req = tracing && (cof_valid_i || ext_edge);
    // A coinciding flow change keeps its address; the event only adds the flag
    entry_addr = cof_valid_i ? cof_addr_i : last_pc_i;
    entry = '0;
    entry[dbg_pkg::ADDR_W-1:0] = entry_addr;
    // Indexed jump destinations arrive as COF_DEST at completion, pending IRQ or not
    entry[dbg_pkg::BIT_INFO_SOURCE] = cof_valid_i && (cof_kind_i == dbg_pkg::COF_SOURCE);
    entry[dbg_pkg::BIT_INFO_DEST] = cof_valid_i && (cof_kind_i == dbg_pkg::COF_DEST);
    entry[dbg_pkg::BIT_INFO_VECTOR] = cof_valid_i && (cof_kind_i == dbg_pkg::COF_VECTOR);
    entry[dbg_pkg::BIT_INFO_EXT_EVENT] = ext_edge;

    timestamp_enable_fmt = s_q.tctl[dbg_pkg::BIT_TIMESTAMP_ENABLE]
      && s_q.tctl[dbg_pkg::BIT_SINGLE_SOURCE]
      && (s_q.tctl[dbg_pkg::BIT_TRACE_MODE_LO +: 2] == dbg_pkg::MODE_NORMAL);
    // Loop1 drops a repeat of the previous address to save buffer space
    loop1_skip = (s_q.tctl[dbg_pkg::BIT_TRACE_MODE_LO +: 2] == dbg_pkg::MODE_LOOP1)
      && s_q.prev_valid && (s_q.prev_addr == entry_addr) && !ext_edge;

    if (entry_req && !loop1_skip) begin
      s_d.prev_addr = entry_addr;
      s_d.prev_valid = 1'b1;
      if (timestamp_enable_fmt) begin
        // One entry with its timestamp fills a whole line
        ram_wdata = {{(dbg_pkg::ENTRY_W - dbg_pkg::TIMESTAMP_ENABLE_W){1'b0}}, s_q.timestamp_enable, entry};
        ram_we = 2'h3;
        s_d.cnt = {s_q.cnt[dbg_pkg::CNT_W-1:1] + 6'h01, 1'b0};
      end else begin
        ram_wdata = {entry, entry};
        ram_we = s_q.cnt[0] ? 2'h2 : 2'h1;
        s_d.cnt = s_q.cnt + 7'h01;
      end
    end

    // State sequencer
    unique case (s_q.seq)
      dbg_pkg::SEQ_IDLE: begin
        if (s_q.arm) begin
          s_d.seq = dbg_pkg::SEQ_STATE1;
        end
      end
      dbg_pkg::SEQ_STATE1: begin
        if (!s_q.arm) begin
          s_d.seq = dbg_pkg::SEQ_IDLE;
        end else if (cmp_match) begin
          s_d.seq = dbg_pkg::SEQ_FINAL;
          s_d.arm = 1'b0;
        end
      end
      dbg_pkg::SEQ_FINAL: begin
        if (s_q.arm) begin
          s_d.seq = dbg_pkg::SEQ_STATE1;
        end
      end
      default: begin
        s_d.seq = dbg_pkg::SEQ_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr_i) begin
      if (hit(reg_addr_i, dbg_pkg::OFS_DEBUG_CONTROL)) begin
        s_d.arm = reg_wdata_i[dbg_pkg::BIT_ARM];
        if (reg_wdata_i[dbg_pkg::BIT_ARM] && !s_q.arm) begin
          s_d.cnt = '0;
          s_d.prev_valid = 1'b0;
        end
      end
      if (ctl_wr_ok) begin
        if (hit(reg_addr_i, dbg_pkg::OFS_COMPARATOR_A_CONTROL)) begin
          s_d.actl = reg_wdata_i & dbg_pkg::MASK_COMPARATOR_A_CONTROL;
        end
        if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_HIGH)) begin
          s_d.cmp_addr[23:16] = reg_wdata_i;
        end
        if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_MID)) begin
          s_d.cmp_addr[15:8] = reg_wdata_i;
        end
        if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_LOW)) begin
          s_d.cmp_addr[7:0] = reg_wdata_i;
        end
        if (hit(reg_addr_i, dbg_pkg::OFS_CMP_DATA)) begin
          s_d.cmp_data = reg_wdata_i;
        end
        if (hit(reg_addr_i, dbg_pkg::OFS_TRACE_CONTROL_LOW)) begin
          s_d.tctl = reg_wdata_i & dbg_pkg::MASK_TRACE_CONTROL_LOW;
        end
      end
      if (hit(reg_addr_i, dbg_pkg::OFS_TRACE_READ_LINE)) begin
        s_d.rd_line = reg_wdata_i[dbg_pkg::LINE_IDX_W-1:0];
      end
    end

    // Register reads, answered in the following cycle
    s_d.rdata = dbg_pkg::READ_UNMAPPED;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, dbg_pkg::OFS_DEBUG_CONTROL)) begin
        s_d.rdata = {s_q.arm, 7'h00};
      end else if (hit(reg_addr_i, dbg_pkg::OFS_DEBUG_STATUS)) begin
        s_d.rdata = {profiling_active_i, 4'h0, ssf_code(s_q.seq)};
      end else if (hit(reg_addr_i, dbg_pkg::OFS_TRACE_LINE_COUNTER)) begin
        s_d.rdata = {1'b0, s_q.cnt};
      end else if (hit(reg_addr_i, dbg_pkg::OFS_TRACE_CONTROL_LOW)) begin
        s_d.rdata = s_q.tctl;
      end else if (hit(reg_addr_i, dbg_pkg::OFS_TRACE_READ_LINE)) begin
        s_d.rdata = {2'h0, s_q.rd_line};
      end else if (hit(reg_addr_i, dbg_pkg::OFS_COMPARATOR_A_CONTROL)) begin
        s_d.rdata = s_q.actl;
      end else if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_HIGH)) begin
        s_d.rdata = s_q.cmp_addr[23:16];
      end else if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_MID)) begin
        s_d.rdata = s_q.cmp_addr[15:8];
      end else if (hit(reg_addr_i, dbg_pkg::OFS_CMP_ADDR_LOW)) begin
        s_d.rdata = s_q.cmp_addr[7:0];
      end else if (hit(reg_addr_i, dbg_pkg::OFS_CMP_DATA)) begin
        s_d.rdata = s_q.cmp_data;
      end else if (reg_addr_i[15:3] == dbg_pkg::OFS_TRACE_DATA_BASE[15:3]) begin
        s_d.rdata = ram_rdata[{reg_addr_i[2:0], 3'h0} +: 8];
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.actl <= dbg_pkg::RST_COMPARATOR_A_CONTROL;
      s_q.tctl <= dbg_pkg::RST_TRACE_CONTROL_LOW;
      s_q.seq <= dbg_pkg::SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  // Comparator flop drives the pin directly, keeping match one cycle behind the bus
  assign match_o = cmp_match;
  assign armed_o = s_q.arm;

endmodule : dbg_trace_capture

// File: dv/dbg_trace_capture_properties.sv
// Checker for comparator matching, status encoding and register reads
`timescale 1ns/1ps
module dbg_trace_capture_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Core bus and flow
  input wire logic bus_valid_i,
  input wire logic [23:0] bus_addr_i,
  input wire logic [7:0] bus_data_i,
  input wire logic bus_read_i,
  input wire logic pc_valid_i,
  input wire logic [23:0] pc_i,
  input wire logic profiling_active_i,
  // Status
  input wire logic match_o,
  input wire logic armed_o
);
  // ====================
  // Shadow settings; writes are dropped while armed or profiling
  logic [7:0] actl_q;
  logic [23:0] caddr_q;
  logic [7:0] cdata_q;
  logic wen;
  logic addr_hit;
  logic data_ok;
  logic dir_ok;
  logic pc_hit;
  logic exp_match;
  assign wen = reg_wr_i && !armed_o && !profiling_active_i;
  assign addr_hit = bus_valid_i && bus_addr_i == caddr_q;
  assign data_ok = (bus_data_i == cdata_q) ^ actl_q[6];
  assign dir_ok = !actl_q[2] || bus_read_i == actl_q[3];
  assign pc_hit = pc_valid_i && pc_i == caddr_q;
  assign exp_match = actl_q[0] && (actl_q[5] ? pc_hit : addr_hit && data_ok && dir_ok);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      actl_q <= dbg_pkg::RST_COMPARATOR_A_CONTROL;
      caddr_q <= 24'h000000;
      cdata_q <= 8'h00;
    end else if (wen) begin
      if (reg_addr_i == 16'h0110) actl_q <= reg_wdata_i & dbg_pkg::MASK_COMPARATOR_A_CONTROL;
      if (reg_addr_i == 16'h0115) caddr_q[23:16] <= reg_wdata_i;
      if (reg_addr_i == 16'h0116) caddr_q[15:8] <= reg_wdata_i;
      if (reg_addr_i == 16'h0117) caddr_q[7:0] <= reg_wdata_i;
      if (reg_addr_i == 16'h0118) cdata_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ====================
  // Properties
  property p_rd_quiet; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_ctl_read; reg_rd_i && reg_addr_i == 16'h0110 |=> reg_rdata_o == actl_q; endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  property p_ssf; reg_rd_i && reg_addr_i == 16'h0102 |=> reg_rdata_o[2:0] < 3'h5; endproperty
  a_ssf: assert property (p_ssf) else $error("reserved sequence flag");
  property p_off; !actl_q[0] |=> !match_o; endproperty
  a_off: assert property (p_off) else $error("match while disabled");
  property p_pc; actl_q[0] && actl_q[5] |=> match_o == $past(pc_hit); endproperty
  a_pc: assert property (p_pc) else $error("pc compare wrong");
  property p_data; actl_q[0] && !actl_q[5] && addr_hit && dir_ok |=> match_o == $past(data_ok);
  endproperty
  a_data: assert property (p_data) else $error("data condition wrong");
  property p_dir; actl_q[0] && !actl_q[5] && actl_q[2] && addr_hit && data_ok
    && bus_read_i != actl_q[3] |=> !match_o; endproperty
  a_dir: assert property (p_dir) else $error("direction not qualified");
  property p_rwe; actl_q[0] && !actl_q[5] && !actl_q[2] && addr_hit && data_ok |=> match_o;
  endproperty
  a_rwe: assert property (p_rwe) else $error("direction not ignored");
  property p_all; match_o |-> $past(exp_match); endproperty
  a_all: assert property (p_all) else $error("match without all qualifiers");
endmodule : dbg_trace_capture_properties

bind dbg_trace_capture dbg_trace_capture_properties dbg_trace_capture_properties_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i), .bus_data_i(bus_data_i),
  .bus_read_i(bus_read_i), .pc_valid_i(pc_valid_i), .pc_i(pc_i),
  .profiling_active_i(profiling_active_i), .match_o(match_o), .armed_o(armed_o)
);

// File: dv/core_model.sv
// Behavioural core: data accesses, instructions, flow changes and event pin
`timescale 1ns/1ps
module core_model (
  // Clock
  input wire logic clk_i,
  // Data bus
  output logic bus_valid_o = 1'b0,
  output logic [23:0] bus_addr_o = 24'h000000,
  output logic [7:0] bus_data_o = 8'h00,
  output logic bus_read_o = 1'b0,
  // Program flow
  output logic pc_valid_o = 1'b0,
  output logic [23:0] pc_o = 24'h000000,
  output logic [23:0] last_pc_o = 24'h000000,
  output logic cof_valid_o = 1'b0,
  output logic [1:0] cof_kind_o = 2'h0,
  output logic [23:0] cof_addr_o = 24'h000000,
  // Event pin
  output logic ext_event_o = 1'b0
);
  // ====================
  // Released lines flip so that stale values can never fake a match
  task automatic access(input logic [23:0] a, input logic [7:0] d, input logic r);
    @(posedge clk_i);
    bus_valid_o <= 1'b1;
    bus_addr_o <= a;
    bus_data_o <= d;
    bus_read_o <= r;
    @(posedge clk_i);
    bus_valid_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_data_o <= ~d;
    bus_read_o <= ~r;
  endtask : access
  task automatic step(input logic [23:0] a);
    @(posedge clk_i);
    pc_valid_o <= 1'b1;
    pc_o <= a;
    last_pc_o <= a;
    @(posedge clk_i);
    pc_valid_o <= 1'b0;
    pc_o <= ~a;
  endtask : step
  task automatic flow(input logic [1:0] k, input logic [23:0] a);
    @(posedge clk_i);
    cof_valid_o <= 1'b1;
    cof_kind_o <= k;
    cof_addr_o <= a;
    @(posedge clk_i);
    cof_valid_o <= 1'b0;
    cof_addr_o <= ~a;
  endtask : flow
  task automatic set_event(input logic v);
    @(posedge clk_i);
    ext_event_o <= v;
  endtask : set_event
endmodule : core_model

// File: dv/tb_top.sv
// Self-checking bench for debug comparator and trace capture
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic prof = 1'b0;
  logic [7:0] reg_rdata_o;
  logic match_o;
  logic armed_o;
  logic bv, br, pv, cv, ev;
  logic [23:0] ba, pc, lpc, ca;
  logic [7:0] bd;
  logic [1:0] ck;
  logic [7:0] b;
  logic [63:0] ln;
  int errors = 0;
  int samples_checked = 0;
  int d = -1;
  localparam logic [31:0] EVB = 32'h1 << dbg_pkg::BIT_INFO_EXT_EVENT;
  localparam logic [23:0] CA = 24'h123456;

  always #10 clk_i = ~clk_i;

  dbg_trace_capture dbg_trace_capture_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .bus_valid_i(bv), .bus_addr_i(ba), .bus_data_i(bd), .bus_read_i(br),
    .pc_valid_i(pv), .pc_i(pc), .last_pc_i(lpc), .cof_valid_i(cv), .cof_kind_i(ck),
    .cof_addr_i(ca), .profiling_active_i(prof), .ext_event_i(ev),
    .match_o(match_o), .armed_o(armed_o)
  );
  core_model core_model_i (
    .clk_i(clk_i), .bus_valid_o(bv), .bus_addr_o(ba), .bus_data_o(bd), .bus_read_o(br),
    .pc_valid_o(pv), .pc_o(pc), .last_pc_o(lpc), .cof_valid_o(cv), .cof_kind_o(ck),
    .cof_addr_o(ca), .ext_event_o(ev)
  );

  // ====================
  // Access tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 b = reg_rdata_o;
  endtask : rd
  task automatic rd_line(input logic [5:0] i);
    wr(16'h010A, {2'b00, i});
    for (int n = 0; n < 8; n++) begin
      rd(16'h0120 + 16'(n));
      ln[8*n +: 8] = b;
    end
  endtask : rd_line
  function automatic logic [31:0] ent(input int k, input logic [23:0] a);
    return {8'h00, a} | (32'h1 << k);
  endfunction : ent
  // Flags are {pc mode, read access, expected match}
  task automatic cmp(input logic [7:0] c, input logic [2:0] f, input logic [23:0] a,
                     input logic [7:0] v);
    wr(16'h0110, c);
    if (f[2]) begin
      core_model_i.step(a);
    end else begin
      core_model_i.access(a, v, f[1]);
    end
    #1 check(64'(match_o), 64'(f[0]));
  endtask : cmp
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // ====================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(16'h0110);
    check(64'(b), 64'(dbg_pkg::RST_COMPARATOR_A_CONTROL));
    rd(16'h01FF);
    check(64'(b), 64'(dbg_pkg::READ_UNMAPPED));
    wr(16'h0115, 8'h12);
    wr(16'h0116, 8'h34);
    wr(16'h0117, 8'h56);
    wr(16'h0118, 8'hA5);
    cmp(8'h00, 3'b000, CA, 8'hA5);
    cmp(8'h01, 3'b001, CA, 8'hA5);
    cmp(8'h01, 3'b000, 24'h123457, 8'hA5);
    cmp(8'h01, 3'b000, CA, 8'h5A);
    cmp(8'h41, 3'b001, CA, 8'h5A);
    cmp(8'h41, 3'b000, CA, 8'hA5);
    cmp(8'h05, 3'b010, CA, 8'hA5);
    cmp(8'h0D, 3'b011, CA, 8'hA5);
    cmp(8'h09, 3'b001, CA, 8'hA5);
    cmp(8'h21, 3'b101, CA, 8'h00);
    cmp(8'h21, 3'b000, CA, 8'hA5);
    cmp(8'h6D, 3'b101, CA, 8'h00);
    wr(16'h0110, 8'h01);
    wr(16'h0100, 8'h80);
    wr(16'h0110, 8'h6D);
    rd(16'h0110);
    check(64'(b), 64'h01);
    rd(16'h0102);
    check(64'(b[2:0]), 64'(dbg_pkg::SSF_STATE1));
    core_model_i.access(CA, 8'hA5, 1'b0);
    rd(16'h0102);
    check(64'({b[2:0], armed_o}), 64'({dbg_pkg::SSF_FINAL, 1'b0}));
    @(posedge clk_i);
    prof <= 1'b1;
    wr(16'h0110, 8'h00);
    rd(16'h0110);
    check(64'(b), 64'h01);
    @(posedge clk_i);
    prof <= 1'b0;
    wr(16'h0110, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(16'h0100, 8'h00);
      wr(16'h0107, {3'b000, 1'b1, m == 0 ? dbg_pkg::MODE_NORMAL : dbg_pkg::MODE_LOOP1, 2'b00});
      wr(16'h0100, 8'h80);
      core_model_i.flow(dbg_pkg::COF_SOURCE, 24'h001000 + 24'(m));
      core_model_i.flow(dbg_pkg::COF_DEST, 24'h002000 + 24'(m));
      core_model_i.flow(dbg_pkg::COF_VECTOR, 24'h00FFF2);
      rd(16'h0106);
      check(64'(b), 64'h03);
      rd_line(6'h00);
      check(ln, {ent(dbg_pkg::BIT_INFO_DEST, 24'h002000 + 24'(m)),
                 ent(dbg_pkg::BIT_INFO_SOURCE, 24'h001000 + 24'(m))});
      rd_line(6'h01);
      check(64'(ln[31:0]), 64'(ent(dbg_pkg::BIT_INFO_VECTOR, 24'h00FFF2)));
    end
    wr(16'h0100, 8'h00);
    wr(16'h0107, 8'h10);
    wr(16'h0100, 8'h80);
    core_model_i.step(24'h003456);
    // Event latency is learnt from a lone event, then reused to land on a flow change
    @(posedge clk_i);
    reg_addr_i <= 16'h0106;
    reg_rd_i <= 1'b1;
    core_model_i.set_event(1'b1);
    for (int j = 1; j < 20 && d < 0; j++) begin
      @(posedge clk_i);
      #1 if (reg_rdata_o === 8'h01) d = j - 2;
    end
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    core_model_i.set_event(1'b0);
    if (d < 1) begin
      errors++;
    end else begin
      rd_line(6'h00);
      check(64'(ln[31:0]), 64'({8'h00, 24'h003456} | EVB));
      core_model_i.set_event(1'b1);
      repeat (d - 1) @(posedge clk_i);
      core_model_i.flow(dbg_pkg::COF_SOURCE, 24'h004000);
      core_model_i.set_event(1'b0);
      repeat (6) @(posedge clk_i);
      rd(16'h0106);
      check(64'(b), 64'h02);
      rd_line(6'h00);
      check(64'(ln[63:32]), 64'(ent(dbg_pkg::BIT_INFO_SOURCE, 24'h004000) | EVB));
    end
    wr(16'h0100, 8'h00);
    wr(16'h0107, 8'h13);
    wr(16'h0100, 8'h80);
    core_model_i.flow(dbg_pkg::COF_SOURCE, 24'h005000);
    rd(16'h0106);
    check(64'(b), 64'h02);
    rd_line(6'h00);
    check(64'({ln[63:48], ln[31:0]}), 64'(ent(dbg_pkg::BIT_INFO_SOURCE, 24'h005000)));
    complete_run();
  end
endmodule : tb_top
